// ==== common/fdc_status_regs.vh ====
// Purpose: offsets, field positions, reset values and modes of the drive status and control block
// Assumes: included by bare name from the design file
// Notes: offsets are relative to the controller base address
`ifndef FDC_STATUS_REGS_VH
`define FDC_STATUS_REGS_VH

// register offsets
`define OFS_STATUS_A 3'h0
`define OFS_STATUS_B 3'h1
`define OFS_OUTPUT_CTRL 3'h2
`define OFS_TAPE_SELECT 3'h3
`define OFS_MAIN_STATUS 3'h4
`define OFS_RATE_SELECT 3'h4
`define OFS_CMD_DATA 3'h5
`define OFS_RESERVED 3'h6
`define OFS_INPUT_STATUS 3'h7
`define OFS_CONFIG_CTRL 3'h7

// output control fields
`define OC_DRIVE_SEL_LO 0
`define OC_DRIVE_SEL_HI 1
`define OC_SOFT_RESET_N 2
`define OC_DMA_GATE 3
`define OC_MOTOR_LO 4
`define OC_MOTOR_HI 7
`define OC_RESET_VALUE 8'h00

// compatibility modes
`define MODE_PLAIN 2'h0
`define MODE_EXTENDED 2'h1
`define MODE_ALTERNATE 2'h2

// fixed bits of extended status b
`define SB_EXT_FIXED 2'h3

// least soft reset time, ns, and the clock period, ns
`define SOFT_RESET_MIN_NS 100
`define CLK_PERIOD_NS 40

`endif

// ==== logic/fdc_status_drive_control.v ====
// Purpose: host-visible status a/b and drive output control of a floppy disk controller
// Assumes: ISA-style strobes from pins, controller core on the same clock
// Notes: only status a/b and output control are held here; other offsets except reserved offset 6 go to the core
// Overview of operation
// [RULE1]: eight offsets decoded; 0 to 2 held here, offset 6 reserved, others handed to the core.
// [RULE2]: plain mode reads of status a and b leave the bus undriven.
// [RULE3]: extended status a layout: int, drive2_n, step, trk0_n, side, index_n, wp_n, dir.
// [RULE4]: alternate status a: int, drq, step latch, trk0, side_n, index, wp, dir_n.
// [RULE5]: step latch sets on step going active; clears on input read or resets.
// [RULE6]: extended status b: 1,1, select bit 0, wr toggle, rd toggle, gate, motors 1,0.
// [RULE7]: read and write data inactive edges flip their toggle bits.
// [RULE8]: motor and select mirrors clear on hardware reset only.
// [RULE9]: alternate status b: drive2_n, sel1_n, sel0_n, latches, sel3_n, sel2_n.
// [RULE10]: gate latch on gate rise, data latches on inactive edges, cleared by input read.
// [RULE11]: output control: motors 7..4, dma gate, soft reset_n, select; resets to zero.
// [RULE12]: select bits decode to exactly one of four select lines; none while the controller is in reset.
// [RULE13]: writing 0 to bit 2 holds the controller in reset until 1 written.
// [RULE14]: software holds soft reset at least 100 ns; two writes suffice.
// [RULE15]: plain and alternate modes gate dma and interrupt pins with the dma gate bit.
// [RULE16]: extended mode keeps dma and interrupt pins enabled, even during soft reset; hardware reset disables them.
// [RULE17]: each motor bit drives its motor-on output active.
// [RULE18]: software activates drives 0..3 with 1C, 2D, 4E, 8F.
// [RULE19]: status a and b reads blocked in configuration mode.
// [RULE20]: static mode input switches layouts and gating, keeping output control contents.
`include "fdc_status_regs.vh"

module fdc_status_drive_control (
  // clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // host i/o bus pins
  input wire io_rd_n_in,
  input wire io_wr_n_in,
  input wire [2:0] io_addr_in,
  input wire [7:0] io_data_in,
  output reg [7:0] io_data_out,
  output reg io_data_oe_out,
  // strap and configuration state
  input wire [1:0] compat_mode_in,
  input wire config_mode_in,
  // controller core, same clock
  input wire step_in,
  input wire write_gate_in,
  input wire write_data_n_in,
  input wire direction_in,
  input wire head_side_in,
  input wire floppy_interrupt_in,
  input wire drq_in,
  input wire [7:0] core_rdata_in,
  output reg core_rd_out,
  output reg core_wr_out,
  output reg [2:0] core_addr_out,
  output reg [7:0] core_wdata_out,
  output reg ctrl_reset_out,
  output reg dack_n_gated_out,
  output reg tc_gated_out,
  // drive interface pins
  input wire second_drive_present_n_in,
  input wire track_zero_n_in,
  input wire index_pulse_n_in,
  input wire write_protect_n_in,
  input wire read_data_n_in,
  input wire dack_n_in,
  input wire tc_in,
  output reg [3:0] drive_select_line_n_out,
  output reg [3:0] motor_on_n_out,
  output reg floppy_interrupt_out,
  output reg floppy_interrupt_oe_out,
  output reg drq_out,
  output reg drq_oe_out
);

  // two-stage synchronisers for every pin input
  reg [19:0] pin_meta_reg;
  reg [19:0] pin_sync_reg;
  wire [19:0] pin_raw = {io_rd_n_in, io_wr_n_in, io_addr_in, io_data_in, second_drive_present_n_in,
                         track_zero_n_in, index_pulse_n_in, write_protect_n_in, read_data_n_in,
                         dack_n_in, tc_in};

  // reset to idle pin levels, tc low, so no false strobe or count follows reset
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      pin_meta_reg <= 20'hFFFFE;
      pin_sync_reg <= 20'hFFFFE;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire rd_n_s = pin_sync_reg[19];
  wire wr_n_s = pin_sync_reg[18];
  wire [2:0] addr_s = pin_sync_reg[17:15];
  wire [7:0] wdata_s = pin_sync_reg[14:7];
  wire drive2_n_s = pin_sync_reg[6];
  wire trk0_n_s = pin_sync_reg[5];
  wire index_n_s = pin_sync_reg[4];
  wire wp_n_s = pin_sync_reg[3];
  wire rdata_n_s = pin_sync_reg[2];
  wire dack_n_s = pin_sync_reg[1];
  wire tc_s = pin_sync_reg[0];

  // edge history of strobes and disk signals
  reg rd_n_d_reg;
  reg wr_n_d_reg;
  reg rdata_n_d_reg;
  reg wdata_n_d_reg;
  reg step_d_reg;
  reg write_gate_d_reg;

  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      rd_n_d_reg <= 1'b1;
      wr_n_d_reg <= 1'b1;
      rdata_n_d_reg <= 1'b1;
      wdata_n_d_reg <= 1'b1;
      step_d_reg <= 1'b0;
      write_gate_d_reg <= 1'b0;
    end
    else
    begin
      rd_n_d_reg <= rd_n_s;
      wr_n_d_reg <= wr_n_s;
      rdata_n_d_reg <= rdata_n_s;
      wdata_n_d_reg <= write_data_n_in;
      step_d_reg <= step_in;
      write_gate_d_reg <= write_gate_in;
    end
  end

  // one access per strobe, taken on its falling edge
  wire rd_start = rd_n_d_reg & ~rd_n_s;
  wire wr_start = wr_n_d_reg & ~wr_n_s;
  wire rd_end = rd_n_s;
  wire rdata_inactive_edge = ~rdata_n_d_reg & rdata_n_s;
  wire wdata_inactive_edge = ~wdata_n_d_reg & write_data_n_in;
  wire step_rise = ~step_d_reg & step_in;
  wire write_gate_rise = ~write_gate_d_reg & write_gate_in;
  wire input_read = rd_start & (addr_s == `OFS_INPUT_STATUS);

  // output control register
  reg [7:0] out_ctrl_reg;
  wire [7:0] out_ctrl_next;
  assign out_ctrl_next = (wr_start && addr_s == `OFS_OUTPUT_CTRL) ? wdata_s : out_ctrl_reg;

  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      out_ctrl_reg <= `OC_RESET_VALUE; // [RULE11] [RULE8]
    else
      out_ctrl_reg <= out_ctrl_next; // [RULE11] [RULE20]
  end

  // hardware or software reset of the controller
  reg ctrl_reset_reg;
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      ctrl_reset_reg <= 1'b1;
    else
      ctrl_reset_reg <= ~out_ctrl_next[`OC_SOFT_RESET_N]; // [RULE13] [RULE14]
  end

  // event latches and toggles; a set in the clearing cycle wins
  reg step_latch_reg;
  reg write_gate_latch_reg;
  reg rdata_latch_reg;
  reg wdata_latch_reg;
  reg rdata_toggle_reg;
  reg wdata_toggle_reg;

  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      step_latch_reg <= 1'b0;
      write_gate_latch_reg <= 1'b0;
      rdata_latch_reg <= 1'b0;
      wdata_latch_reg <= 1'b0;
      rdata_toggle_reg <= 1'b0;
      wdata_toggle_reg <= 1'b0;
    end
    else
    begin
      step_latch_reg <= step_rise | (step_latch_reg & ~input_read & ~ctrl_reset_reg); // [RULE5]
      write_gate_latch_reg <= write_gate_rise | (write_gate_latch_reg & ~input_read); // [RULE10]
      rdata_latch_reg <= rdata_inactive_edge | (rdata_latch_reg & ~input_read); // [RULE10]
      // write latch deliberately not qualified by write gate
      wdata_latch_reg <= wdata_inactive_edge | (wdata_latch_reg & ~input_read); // [RULE10]
      rdata_toggle_reg <= rdata_toggle_reg ^ rdata_inactive_edge; // [RULE7]
      wdata_toggle_reg <= wdata_toggle_reg ^ wdata_inactive_edge; // [RULE7]
    end
  end

  // binary select decode; lines stay idle while the controller is in reset
  function [3:0] select_decode;
    input [1:0] sel;
    input hold;
    begin
      select_decode = hold ? 4'hF : ~(4'h1 << sel); // [RULE12]
    end
  endfunction

  wire [3:0] select_n;
  wire [3:0] motor_bits;
  assign select_n = select_decode(out_ctrl_next[`OC_DRIVE_SEL_HI:`OC_DRIVE_SEL_LO],
                                  ~out_ctrl_next[`OC_SOFT_RESET_N]);
  assign motor_bits = out_ctrl_reg[`OC_MOTOR_HI:`OC_MOTOR_LO];

  // live core bits read as idle during reset so status shows its reset values
  wire live_int;
  wire live_step;
  wire live_side;
  wire live_dir;
  assign live_int = floppy_interrupt_in & ~ctrl_reset_reg;
  assign live_step = step_in & ~ctrl_reset_reg;
  assign live_side = head_side_in & ~ctrl_reset_reg;
  assign live_dir = direction_in & ~ctrl_reset_reg;

  wire [7:0] status_a_ext;
  wire [7:0] status_a_alt;
  wire [7:0] status_b_ext;
  wire [7:0] status_b_alt;
  assign status_a_ext = {live_int, drive2_n_s, live_step, trk0_n_s, live_side, index_n_s,
                         wp_n_s, live_dir}; // [RULE3]
  assign status_a_alt = {live_int, drq_in & ~ctrl_reset_reg, step_latch_reg, ~trk0_n_s,
                         ~live_side, ~index_n_s, ~wp_n_s, ~live_dir}; // [RULE4]
  assign status_b_ext = {`SB_EXT_FIXED, out_ctrl_reg[`OC_DRIVE_SEL_LO], wdata_toggle_reg,
                         rdata_toggle_reg, write_gate_in, motor_bits[1:0]}; // [RULE6] [RULE8]
  assign status_b_alt = {drive2_n_s, drive_select_line_n_out[1:0], wdata_latch_reg,
                         rdata_latch_reg, write_gate_latch_reg,
                         drive_select_line_n_out[3:2]}; // [RULE9]

  // read data choice; flag low leaves the bus undriven
  reg [7:0] rd_value;
  reg rd_drive;
  always @*
  begin
    rd_value = 8'h00;
    rd_drive = 1'b0;
    case (addr_s)
      `OFS_STATUS_A:
      begin
        rd_drive = (compat_mode_in != `MODE_PLAIN) & ~config_mode_in; // [RULE2] [RULE19]
        rd_value = (compat_mode_in == `MODE_EXTENDED) ? status_a_ext : status_a_alt; // [RULE20]
      end
      `OFS_STATUS_B:
      begin
        rd_drive = (compat_mode_in != `MODE_PLAIN) & ~config_mode_in; // [RULE2] [RULE19]
        rd_value = (compat_mode_in == `MODE_EXTENDED) ? status_b_ext : status_b_alt; // [RULE20]
      end
      `OFS_OUTPUT_CTRL:
      begin
        rd_drive = 1'b1;
        rd_value = out_ctrl_reg;
      end
      `OFS_RESERVED:
      begin
        rd_drive = 1'b0; // [RULE1]
        rd_value = 8'h00;
      end
      default:
      begin
        // tape, main status, data and input registers belong to the core
        rd_drive = 1'b1;
        rd_value = core_rdata_in;
      end
    endcase
  end

  function is_core_offset;
    input [2:0] ofs;
    begin
      is_core_offset = (ofs == `OFS_TAPE_SELECT) | (ofs == `OFS_MAIN_STATUS) |
                       (ofs == `OFS_CMD_DATA) | (ofs == `OFS_INPUT_STATUS); // [RULE1]
    end
  endfunction

  // host read bus: captured at strobe start, core data refreshed while held
  reg rd_active_reg;
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      rd_active_reg <= 1'b0;
      io_data_out <= 8'h00;
      io_data_oe_out <= 1'b0;
    end
    else if (rd_start)
    begin
      rd_active_reg <= 1'b1;
      io_data_out <= rd_value;
      io_data_oe_out <= rd_drive;
    end
    else if (rd_end)
    begin
      rd_active_reg <= 1'b0;
      io_data_out <= 8'h00;
      io_data_oe_out <= 1'b0;
    end
    else if (rd_active_reg && is_core_offset(addr_s))
      io_data_out <= core_rdata_in;
  end

  // hand-off of core offsets
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      core_rd_out <= 1'b0;
      core_wr_out <= 1'b0;
      core_addr_out <= 3'h0;
      core_wdata_out <= 8'h00;
    end
    else
    begin
      core_rd_out <= rd_start & is_core_offset(addr_s); // [RULE1]
      core_wr_out <= wr_start & is_core_offset(addr_s); // [RULE1]
      if ((rd_start | wr_start) && is_core_offset(addr_s))
      begin
        core_addr_out <= addr_s;
        core_wdata_out <= wdata_s;
      end
    end
  end

  // pin gating by mode and dma gate
  wire pins_enabled;
  assign pins_enabled = (compat_mode_in == `MODE_EXTENDED) | out_ctrl_next[`OC_DMA_GATE]; // [RULE15] [RULE16]

  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      drive_select_line_n_out <= 4'hF;
      motor_on_n_out <= 4'hF;
      ctrl_reset_out <= 1'b1;
      floppy_interrupt_out <= 1'b0;
      floppy_interrupt_oe_out <= 1'b0;
      drq_out <= 1'b0;
      drq_oe_out <= 1'b0;
      dack_n_gated_out <= 1'b1;
      tc_gated_out <= 1'b0;
    end
    else
    begin
      drive_select_line_n_out <= select_n; // [RULE12]
      motor_on_n_out <= ~out_ctrl_next[`OC_MOTOR_HI:`OC_MOTOR_LO]; // [RULE17]
      ctrl_reset_out <= ~out_ctrl_next[`OC_SOFT_RESET_N]; // [RULE13]
      floppy_interrupt_out <= floppy_interrupt_in & pins_enabled;
      floppy_interrupt_oe_out <= pins_enabled; // [RULE15] [RULE16]
      drq_out <= drq_in & pins_enabled;
      drq_oe_out <= pins_enabled; // [RULE15] [RULE16]
      dack_n_gated_out <= dack_n_s | ~pins_enabled; // [RULE15]
      tc_gated_out <= tc_s & pins_enabled; // [RULE15]
    end
  end

endmodule // fdc_status_drive_control

// ==== tb/fdc_host_model.sv ====
// Purpose: host i/o bus master for the drive status block
// Assumes: strobes seen 3 edges after the pin falls
// Notes: released data lines show the inverse of the last byte
module fdc_host_model (
  // clock
  input wire core_clk_in,
  // read return
  input wire [7:0] rdata_in,
  input wire oe_in,
  // strobes and lines
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [2:0] addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 3'h0;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_n_out <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    wr_n_out <= 1'b1;
    wdata_out <= ~d;
    repeat (4) @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(posedge core_clk_in);
    addr_out <= a;
    rd_n_out <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    d = rdata_in;
    oe = oe_in;
    rd_n_out <= 1'b1;
    // two idle cycles at least before the next strobe
    repeat (4) @(posedge core_clk_in);
  endtask
endmodule // fdc_host_model

// ==== tb/fdc_status_chk_sva.sv ====
// Purpose: port assertions for the drive status and control block
// Assumes: bound to the design top; mode input only changes under reset
// Notes: selects held inactive while the controller is in reset
`include "fdc_status_regs.vh"
module fdc_status_chk (
  // clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // host bus and straps
  input wire [2:0] io_addr_in,
  input wire io_data_oe_out,
  input wire [1:0] compat_mode_in,
  input wire config_mode_in,
  // core side
  input wire core_rd_out,
  input wire core_wr_out,
  input wire [2:0] core_addr_out,
  input wire ctrl_reset_out,
  input wire dack_n_gated_out,
  input wire tc_gated_out,
  // drive pins
  input wire [3:0] drive_select_line_n_out,
  input wire [3:0] motor_on_n_out,
  input wire floppy_interrupt_oe_out,
  input wire drq_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  chk_select_one_hot: assert property ($countones(~drive_select_line_n_out) <= 1)
    else $error("more than one drive selected");
  chk_reset_idle_pins: assert property ($past(sys_rst_in) |-> ctrl_reset_out
    && drive_select_line_n_out == 4'hF && motor_on_n_out == 4'hF) else $error("pins not idle after reset");
  chk_plain_no_drive: assert property ($rose(io_data_oe_out) |->
    !(compat_mode_in == `MODE_PLAIN && io_addr_in <= 3'h1)) else $error("status driven in plain mode");
  chk_config_blocks: assert property ($rose(io_data_oe_out) |-> !(config_mode_in && io_addr_in <= 3'h1))
    else $error("status driven in config mode");
  chk_reserved_silent: assert property ($rose(io_data_oe_out) |-> io_addr_in != 3'h6)
    else $error("reserved offset drove bus");
  chk_core_rd_pulse: assert property (core_rd_out |-> (core_addr_out inside {3, 4, 5, 7}) ##1 !core_rd_out)
    else $error("bad core read pulse");
  chk_core_wr_offset: assert property (core_wr_out |-> !(core_addr_out inside {0, 1, 2, 6}))
    else $error("bad core write offset");
  chk_ext_pins_live: assert property (compat_mode_in == `MODE_EXTENDED && !$past(sys_rst_in) |->
    floppy_interrupt_oe_out && drq_oe_out) else $error("extended mode pins gated");
  chk_gate_pair: assert property (drq_oe_out == floppy_interrupt_oe_out)
    else $error("dma and interrupt gating differ");
  chk_gated_inputs: assert property (!drq_oe_out && !$past(sys_rst_in) |->
    dack_n_gated_out && !tc_gated_out) else $error("ack or count passed while gated");
  chk_reset_deselect: assert property (ctrl_reset_out |-> drive_select_line_n_out == 4'hF)
    else $error("drive selected during reset");
endmodule // fdc_status_chk

// ==== tb/tb_fdc_status_drive_control.sv ====
// Purpose: self-checking bench of the drive status and control block
// Assumes: 25 MHz clock, synchronous reset held 12 cycles
// Notes: mode changes only under hardware reset
`include "fdc_status_regs.vh"
module tb_fdc_status_drive_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in, sys_rst_in, io_rd_n_in, io_wr_n_in, io_data_oe_out, config_mode_in, step_in, write_gate_in;
  logic write_data_n_in, direction_in, head_side_in, floppy_interrupt_in, drq_in, core_rd_out, core_wr_out;
  logic ctrl_reset_out, dack_n_gated_out, tc_gated_out, second_drive_present_n_in, track_zero_n_in;
  logic index_pulse_n_in, write_protect_n_in, read_data_n_in, dack_n_in, tc_in, floppy_interrupt_out;
  logic floppy_interrupt_oe_out, drq_out, drq_oe_out, oe;
  logic [1:0] compat_mode_in;
  logic [2:0] io_addr_in, core_addr_out;
  logic [7:0] io_data_in, io_data_out, core_rdata_in, core_wdata_out, v;
  logic [3:0] drive_select_line_n_out, motor_on_n_out;
  int n_mismatch = 0;
  int n_checks = 0;
  fdc_status_drive_control uut (.core_clk_in, .sys_rst_in, .io_rd_n_in, .io_wr_n_in, .io_addr_in, .io_data_in,
    .io_data_out, .io_data_oe_out, .compat_mode_in, .config_mode_in, .step_in, .write_gate_in, .write_data_n_in,
    .direction_in, .head_side_in, .floppy_interrupt_in, .drq_in, .core_rdata_in, .core_rd_out, .core_wr_out,
    .core_addr_out, .core_wdata_out, .ctrl_reset_out, .dack_n_gated_out, .tc_gated_out, .second_drive_present_n_in,
    .track_zero_n_in, .index_pulse_n_in, .write_protect_n_in, .read_data_n_in, .dack_n_in, .tc_in,
    .drive_select_line_n_out, .motor_on_n_out, .floppy_interrupt_out, .floppy_interrupt_oe_out, .drq_out, .drq_oe_out);
  fdc_host_model host (.core_clk_in, .rdata_in(io_data_out), .oe_in(io_data_oe_out), .rd_n_out(io_rd_n_in),
    .wr_n_out(io_wr_n_in), .addr_out(io_addr_in), .wdata_out(io_data_in));
  initial
  begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read with expected enable; data only judged when driven
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input logic en);
    host.rd(a, v, oe);
    chk({7'h00, oe}, {7'h00, en});
    if (en)
      chk(v, exp);
  endtask
  task automatic gate_is(input logic [1:0] exp);
    chk({6'h00, drq_oe_out, floppy_interrupt_oe_out}, {6'h00, exp});
  endtask
  // which: bit0 step, bit1 write gate, bit2 read data, bit3 write data; each pulsed to its active level
  task automatic pulse(input logic [3:0] which);
    {write_data_n_in, read_data_n_in, write_gate_in, step_in} <= 4'hC ^ which;
    repeat (2) @(posedge core_clk_in);
    {write_data_n_in, read_data_n_in, write_gate_in, step_in} <= 4'hC;
    repeat (5) @(posedge core_clk_in);
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    compat_mode_in <= m;
    repeat (12) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask
  task automatic t_ext_reset;
    index_pulse_n_in <= 1'b0;
    write_protect_n_in <= 1'b0;
    do_reset(`MODE_EXTENDED);
    rdc(`OFS_STATUS_A, 8'h50, 1'b1);
    rdc(`OFS_STATUS_B, 8'hC0, 1'b1);
    rdc(`OFS_OUTPUT_CTRL, `OC_RESET_VALUE, 1'b1);
    gate_is(2'b11);
    config_mode_in <= 1'b1;
    rdc(`OFS_STATUS_A, 8'h00, 1'b0);
    config_mode_in <= 1'b0;
    rdc(`OFS_RESERVED, 8'h00, 1'b0);
    $display("test ext reset done");
  endtask
  task automatic t_drives;
    for (int i = 0; i < 4; i++)
    begin
      v = (8'h10 << i) | 8'h0C | i[7:0];
      host.wr(`OFS_OUTPUT_CTRL, v);
      chk({drive_select_line_n_out, motor_on_n_out}, {~(4'h1 << i), ~(4'h1 << i)});
      rdc(`OFS_STATUS_B, {2'b11, v[0], 3'b000, v[5:4]}, 1'b1);
    end
    $display("test drives done");
  endtask
  task automatic t_soft_reset;
    host.wr(`OFS_OUTPUT_CTRL, 8'h2D);
    host.wr(`OFS_OUTPUT_CTRL, 8'h21);
    chk({3'h0, ctrl_reset_out, drive_select_line_n_out}, 8'h1F);
    gate_is(2'b11);
    rdc(`OFS_STATUS_B, 8'hE2, 1'b1);
    rdc(`OFS_OUTPUT_CTRL, 8'h21, 1'b1);
    host.wr(`OFS_OUTPUT_CTRL, 8'h2D);
    for (int k = 0; k < 8 && ctrl_reset_out !== 1'b0; k++)
      @(posedge core_clk_in);
    chk({7'h00, ctrl_reset_out}, 8'h00);
    if (ctrl_reset_out !== 1'b0)
      stop_test;
    host.wr(`OFS_RESERVED, 8'hFF);
    rdc(`OFS_OUTPUT_CTRL, 8'h2D, 1'b1);
    host.wr(`OFS_TAPE_SELECT, 8'h03);
    chk({5'h00, core_addr_out}, {5'h00, `OFS_TAPE_SELECT});
    chk(core_wdata_out, 8'h03);
    core_rdata_in <= 8'h5A;
    rdc(`OFS_CMD_DATA, 8'h5A, 1'b1);
    $display("test soft reset done");
  endtask
  task automatic t_toggles;
    pulse(4'h4);
    rdc(`OFS_STATUS_B, 8'hEA, 1'b1);
    pulse(4'h8);
    rdc(`OFS_STATUS_B, 8'hFA, 1'b1);
    write_gate_in <= 1'b1;
    rdc(`OFS_STATUS_B, 8'hFE, 1'b1);
    write_gate_in <= 1'b0;
    $display("test toggles done");
  endtask
  task automatic t_alt;
    direction_in <= 1'b1;
    head_side_in <= 1'b1;
    track_zero_n_in <= 1'b0;
    do_reset(`MODE_ALTERNATE);
    rdc(`OFS_STATUS_A, 8'h1F, 1'b1);
    rdc(`OFS_STATUS_B, 8'hE3, 1'b1);
    host.wr(`OFS_OUTPUT_CTRL, 8'h1C);
    gate_is(2'b11);
    pulse(4'h1);
    pulse(4'h2);
    pulse(4'h4);
    pulse(4'h8);
    rdc(`OFS_STATUS_A, 8'h36, 1'b1);
    rdc(`OFS_STATUS_B, 8'hDF, 1'b1);
    rdc(`OFS_INPUT_STATUS, 8'h5A, 1'b1);
    rdc(`OFS_STATUS_A, 8'h16, 1'b1);
    rdc(`OFS_STATUS_B, 8'hC3, 1'b1);
    // interrupt, request, ack and count all active while the gate is open
    {floppy_interrupt_in, drq_in, dack_n_in, tc_in} <= 4'hD;
    repeat (4) @(posedge core_clk_in);
    chk({4'h0, floppy_interrupt_out, drq_out, dack_n_gated_out, tc_gated_out}, 8'h0D);
    rdc(`OFS_STATUS_A, 8'hD6, 1'b1);
    host.wr(`OFS_OUTPUT_CTRL, 8'h14);
    gate_is(2'b00);
    chk({4'h0, floppy_interrupt_out, drq_out, dack_n_gated_out, tc_gated_out}, 8'h02);
    {floppy_interrupt_in, drq_in, dack_n_in, tc_in} <= 4'h2;
    $display("test alternate done");
  endtask
  task automatic t_plain;
    do_reset(`MODE_PLAIN);
    rdc(`OFS_STATUS_A, 8'h00, 1'b0);
    rdc(`OFS_STATUS_B, 8'h00, 1'b0);
    gate_is(2'b00);
    host.wr(`OFS_OUTPUT_CTRL, 8'h1C);
    gate_is(2'b11);
    rdc(`OFS_OUTPUT_CTRL, 8'h1C, 1'b1);
    $display("test plain done");
  endtask
  initial
  begin
    sys_rst_in = 1'b1;
    compat_mode_in = `MODE_EXTENDED;
    {config_mode_in, step_in, write_gate_in, direction_in, head_side_in, floppy_interrupt_in, drq_in, tc_in} = 8'h00;
    {write_data_n_in, read_data_n_in, dack_n_in, second_drive_present_n_in} = 4'hF;
    {track_zero_n_in, index_pulse_n_in, write_protect_n_in} = 3'h7;
    core_rdata_in = 8'h00;
    t_ext_reset;
    t_drives;
    t_soft_reset;
    t_toggles;
    t_alt;
    t_plain;
    stop_test;
  end
endmodule // tb_fdc_status_drive_control
bind fdc_status_drive_control fdc_status_chk chk (.core_clk_in, .sys_rst_in, .io_addr_in, .io_data_oe_out,
  .compat_mode_in, .config_mode_in, .core_rd_out, .core_wr_out, .core_addr_out, .ctrl_reset_out, .dack_n_gated_out,
  .tc_gated_out, .drive_select_line_n_out, .motor_on_n_out, .floppy_interrupt_oe_out, .drq_oe_out);
